// ===== cdd_defines.svh
// register offsets, field positions and reset values of the clock distribution block
`ifndef CDD_DEFINES_SVH
`define CDD_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CDD_OFF_SYSCTL   12'h000
`define CDD_OFF_CMD      12'h004
`define CDD_OFF_INT      12'h100
`define CDD_OFF_FRAC     12'h200
`define CDD_OFF_PCLK     12'h300
`define CDD_WIN_MASK     12'hf00

// ----------------------------------------
// field positions
// ----------------------------------------
`define CDD_EN_BIT       0
`define CDD_INT_MSB      23
`define CDD_INT_LSB      8
`define CDD_FRAC_MSB     7
`define CDD_FRAC_LSB     3
`define CDD_SEL_MSB      7
`define CDD_SEL_LSB      0
`define CDD_REF_MSB      15
`define CDD_REF_LSB      8
`define CDD_PRESC_MSB    3
`define CDD_PRESC_LSB    0
`define CDD_CMD_EN_BIT   31
`define CDD_CMD_DIS_BIT  30

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define CDD_PRESC_RST    4'h0
`define CDD_PRESC_MAX    4'h7
`define CDD_CMD_RST      32'h0000ffff
`define CDD_CMD_MASK     32'hc000ffff
`define CDD_PCLK_RST     8'h00

`endif

// ===== cdd_pkg.sv
// shared types of the clock distribution block
package cdd_pkg;

   // ----------------------------------------
   // divider kinds
   // ----------------------------------------
   typedef enum logic [1:0] {
      cdd_kind_off  = 2'h0,
      cdd_kind_int  = 2'h1,
      cdd_kind_frac = 2'h2,
      cdd_kind_hf   = 2'h3
   } cdd_kind_t;

   // ----------------------------------------
   // divider selection and configuration
   // ----------------------------------------
   typedef struct packed {
      cdd_kind_t   kind;
      logic [5:0]  index;
   } cdd_sel_t;

   typedef struct packed {
      logic [15:0] int_div;
      logic [4:0]  frac;
   } cdd_div_cfg_t;

endpackage

// ===== cdd_divider.sv
// one integer or fractional divider producing one tick per output period
module cdd_divider #(
   parameter bit FRAC = 1'b0
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  enable,
   input  wire logic                  start,
   input  wire cdd_pkg::cdd_div_cfg_t cfg,
   output      logic                  tick
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic        run;
      logic [16:0] cnt;
      logic [4:0]  acc;
      logic        extra;
      logic        tick;
   } cdd_div_state_t;

   cdd_div_state_t st;
   cdd_div_state_t next_st;

   // ----------------------------------------
   // period counter
   // ----------------------------------------
   always_comb begin
      logic [16:0] limit;
      logic [5:0]  sum;
      limit = {1'b0, cfg.int_div} + {16'h0000, st.extra};
      sum = {1'b0, st.acc} + {1'b0, cfg.frac};
      next_st = st;
      next_st.tick = 1'b0;
      if (!enable) begin
         next_st = '0;
      end else if (!st.run) begin
         if (start) begin
            next_st.run = 1'b1;
            next_st.cnt = 17'h00001;
            next_st.acc = FRAC ? cfg.frac : 5'h00;
            next_st.extra = 1'b0;
         end
      end else if (st.cnt >= limit) begin
         next_st.tick = 1'b1;
         next_st.cnt = 17'h00000;
         if (FRAC) begin
            next_st.acc = sum[4:0];
            next_st.extra = sum[5];
         end
      end else begin
         next_st.cnt = st.cnt + 17'h00001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;

endmodule

// ===== cdd_clock_distribution.sv
// clock distribution: system prescaler, dividers, commands and peripheral muxes
// What this block does
// - system tick divides by two to setting, settings above 7 by 128
// - prescale setting resets to divide by one
// - slow root clock is slow oscillator only
// - integer divider period is one plus field
// - fractional field adds fraction over 32
// - fractional periods differ by one cycle
// - enable bit follows enable and disable commands
// - command bit 31 enables, 30 disables
// - type one integer, type two fractional
// - index range checked; 3/63 addresses nothing
// - enable aligns to chosen reference tick while that reference runs
// - aligned divider still counts its own ratio
// - each peripheral muxes any existing divider
// - eleven peripheral outputs, indexed zero to ten
// - select register: index 5:0, type 7:6
//
// Decided for this implementation: the address map and register access over APB.
`include "cdd_defines.svh"

module cdd_clock_distribution #(
   parameter int NI = 6,
   parameter int NF = 2,
   parameter int NP = 11
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output      logic [31:0]   prdata,
   output      logic          pready,
   output      logic          pslverr,
   input  wire logic          slow_internal_osc,
   output      logic          slow_root_clock,
   output      logic          system_clock,
   output      logic [NP-1:0] peripheral_clock_n
);

   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int ND = NI + NF;
   localparam int SW = (ND > 1) ? $clog2(ND) : 1;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [3:0]                     presc_sel;
      logic [6:0]                     presc_cnt;
      logic                           sys_tick;
      logic [31:0]                    cmd;
      logic [ND-1:0]                  en;
      logic [ND-1:0]                  arm;
      logic [ND-1:0]                  ref_free;
      logic [ND-1:0][SW-1:0]          ref_slot;
      cdd_pkg::cdd_div_cfg_t [ND-1:0] cfg;
      cdd_pkg::cdd_sel_t [NP-1:0]     pclk_sel;
      logic [NP-1:0]                  pclk_out;
      logic [31:0]                    rdata;
      logic                           err;
   } cdd_state_t;

   cdd_state_t    st;
   cdd_state_t    next_st;
   logic [ND-1:0] tick;
   logic [ND-1:0] go;
   logic [NP-1:0] mux_tick;

   // ----------------------------------------
   // divider lookup
   // ----------------------------------------
   // msb flags an existing divider, low bits give its slot
   function automatic logic [SW:0] slot_of(input cdd_pkg::cdd_sel_t s);
      logic [SW:0] res;
      res = '0;
      if (s.kind == cdd_pkg::cdd_kind_int && s.index < 6'(NI)) begin
         res = {1'b1, SW'(s.index)};
      end else if (s.kind == cdd_pkg::cdd_kind_frac && s.index < 6'(NF)) begin
         res = {1'b1, SW'(s.index + 6'(NI))};
      end
      return res;
   endfunction

   // ----------------------------------------
   // dividers
   // ----------------------------------------
   genvar gd;
   generate
      for (gd = 0; gd < ND; gd++) begin : g_div
         cdd_divider #(
            .FRAC (gd >= NI)
         ) u_div (
            .pclk    (pclk),
            .presetn (presetn),
            .enable  (st.en[gd]),
            .start   (go[gd]),
            .cfg     (st.cfg[gd]),
            .tick    (tick[gd])
         );
      end
   endgenerate

   // ----------------------------------------
   // peripheral clock muxes
   // ----------------------------------------
   genvar gp;
   generate
      for (gp = 0; gp < NP; gp++) begin : g_mux
         logic [SW:0] hit;
         assign hit = slot_of(st.pclk_sel[gp]);
         assign mux_tick[gp] = hit[SW] & tick[hit[SW-1:0]];
      end
   endgenerate

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [SW:0]   tgt;
      logic [SW:0]   rsl;
      logic [2:0]    shift;
      logic [6:0]    lim;
      logic [11:0]   win;
      logic [5:0]    wi;
      logic [SW-1:0] ds;
      logic          aligned;
      logic          is_sys;
      logic          is_cmd;
      logic          is_int;
      logic          is_frac;
      logic          is_pclk;
      logic [31:0]   rd;
      tgt = '0;
      rsl = '0;
      shift = 3'h0;
      lim = 7'h00;
      win = paddr & `CDD_WIN_MASK;
      wi = paddr[7:2];
      ds = '0;
      aligned = (paddr[1:0] == 2'h0);
      is_sys = 1'b0;
      is_cmd = 1'b0;
      is_int = 1'b0;
      is_frac = 1'b0;
      is_pclk = 1'b0;
      rd = 32'h00000000;
      next_st = st;
      go = '0;

      // ----------------------------------------
      // system prescaler
      // ----------------------------------------
      if (st.presc_sel > `CDD_PRESC_MAX) begin
         shift = 3'(`CDD_PRESC_MAX);
      end else begin
         shift = st.presc_sel[2:0];
      end
      lim = 7'((8'h01 << shift) - 8'h01);
      next_st.sys_tick = 1'b0;
      if (st.presc_cnt >= lim) begin
         next_st.presc_cnt = 7'h00;
         next_st.sys_tick = 1'b1;
      end else begin
         next_st.presc_cnt = st.presc_cnt + 7'h01;
      end

      // ----------------------------------------
      // armed dividers start on the reference tick, or at once when no reference is chosen or it is not running
      // ----------------------------------------
      for (int i = 0; i < ND; i++) begin
         go[i] = st.arm[i] &
                 (st.ref_free[i] |
                  ~(st.en[st.ref_slot[i]] & ~st.arm[st.ref_slot[i]]) |
                  tick[st.ref_slot[i]]);
         if (go[i]) begin
            next_st.arm[i] = 1'b0;
         end
      end

      // ----------------------------------------
      // command execution
      // ----------------------------------------
      tgt = slot_of(cdd_pkg::cdd_sel_t'(st.cmd[`CDD_SEL_MSB:`CDD_SEL_LSB]));
      rsl = slot_of(cdd_pkg::cdd_sel_t'(st.cmd[`CDD_REF_MSB:`CDD_REF_LSB]));
      if (tgt[SW]) begin
         if (st.cmd[`CDD_CMD_DIS_BIT]) begin
            next_st.en[tgt[SW-1:0]] = 1'b0;
            next_st.arm[tgt[SW-1:0]] = 1'b0;
         end else if (st.cmd[`CDD_CMD_EN_BIT]) begin
            next_st.en[tgt[SW-1:0]] = 1'b1;
            next_st.arm[tgt[SW-1:0]] = ~st.en[tgt[SW-1:0]];
            next_st.ref_free[tgt[SW-1:0]] = ~rsl[SW];
            next_st.ref_slot[tgt[SW-1:0]] = rsl[SW-1:0];
         end
      end
      next_st.cmd[`CDD_CMD_EN_BIT] = 1'b0;
      next_st.cmd[`CDD_CMD_DIS_BIT] = 1'b0;

      // ----------------------------------------
      // peripheral ticks
      // ----------------------------------------
      next_st.pclk_out = mux_tick;

      // ----------------------------------------
      // register decode
      // ----------------------------------------
      is_sys = (paddr == `CDD_OFF_SYSCTL);
      is_cmd = (paddr == `CDD_OFF_CMD);
      is_int = aligned && (win == `CDD_OFF_INT) && (wi < 6'(NI));
      is_frac = aligned && (win == `CDD_OFF_FRAC) && (wi < 6'(NF));
      is_pclk = aligned && (win == `CDD_OFF_PCLK) && (wi < 6'(NP));
      if (is_frac) begin
         ds = SW'(wi + 6'(NI));
      end else begin
         ds = SW'(wi);
      end

      // ----------------------------------------
      // read mux
      // ----------------------------------------
      if (is_sys) begin
         rd[`CDD_PRESC_MSB:`CDD_PRESC_LSB] = st.presc_sel;
      end else if (is_cmd) begin
         rd = st.cmd;
      end else if (is_int) begin
         rd[`CDD_INT_MSB:`CDD_INT_LSB] = st.cfg[ds].int_div;
         rd[`CDD_EN_BIT] = st.en[ds];
      end else if (is_frac) begin
         rd[`CDD_INT_MSB:`CDD_INT_LSB] = st.cfg[ds].int_div;
         rd[`CDD_FRAC_MSB:`CDD_FRAC_LSB] = st.cfg[ds].frac;
         rd[`CDD_EN_BIT] = st.en[ds];
      end else if (is_pclk) begin
         rd[`CDD_SEL_MSB:`CDD_SEL_LSB] = st.pclk_sel[wi];
      end

      // ----------------------------------------
      // setup phase captures read data and the error answer
      // ----------------------------------------
      if (psel && !penable) begin
         next_st.rdata = rd;
         next_st.err = ~(is_sys | is_cmd | is_int | is_frac | is_pclk);
      end

      // ----------------------------------------
      // access phase writes
      // ----------------------------------------
      if (psel && penable && pwrite) begin
         if (is_sys) begin
            next_st.presc_sel = pwdata[`CDD_PRESC_MSB:`CDD_PRESC_LSB];
         end
         if (is_cmd) begin
            next_st.cmd = pwdata & `CDD_CMD_MASK;
         end
         if (is_int) begin
            next_st.cfg[ds].int_div = pwdata[`CDD_INT_MSB:`CDD_INT_LSB];
         end
         if (is_frac) begin
            next_st.cfg[ds].int_div = pwdata[`CDD_INT_MSB:`CDD_INT_LSB];
            next_st.cfg[ds].frac = pwdata[`CDD_FRAC_MSB:`CDD_FRAC_LSB];
         end
         if (is_pclk) begin
            next_st.pclk_sel[wi] = cdd_pkg::cdd_sel_t'(pwdata[`CDD_SEL_MSB:`CDD_SEL_LSB]);
         end
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
         st.presc_sel <= `CDD_PRESC_RST;
         st.cmd <= `CDD_CMD_RST;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign pready = 1'b1;
   assign prdata = st.rdata;
   assign pslverr = psel & penable & st.err;
   assign system_clock = st.sys_tick;
   assign peripheral_clock_n = st.pclk_out;
   assign slow_root_clock = slow_internal_osc;

endmodule

// ===== cdd_clock_distribution_properties.sv
// port checker of the clock distribution block
module cdd_checker #(
   parameter int NP = 11
) (
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [11:0]   paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire logic          slow_internal_osc,
   input wire logic          slow_root_clock,
   input wire logic          system_clock,
   input wire logic [NP-1:0] peripheral_clock_n
);
   // ----
   // prescale shadow and tick gap
   // ----
   logic [3:0] sel;
   logic [1:0] pc;
   logic [7:0] gap;
   logic       pw;
   logic       acc;
   assign acc = psel && penable;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel <= 4'h0;
         pc  <= 2'h0;
         gap <= 8'h00;
         pw  <= 1'b0;
      end else begin
         if (acc && pwrite && paddr == 12'h000) begin
            sel <= pwdata[3:0];
            pc  <= 2'h0;
         end else if (system_clock && pc != 2'h2) begin
            pc <= pc + 2'h1;
         end
         gap <= system_clock ? 8'h00 : gap + 8'h01;
         if (acc && pwrite && paddr[11:8] == 4'h3) begin
            pw <= 1'b1;
         end
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   slow_path_a: assert property (slow_root_clock == slow_internal_osc) else $error("slow clock differs");
   bus_ready_a: assert property (acc |-> pready) else $error("no ready");
   err_window_a: assert property (pslverr |-> acc) else $error("error outside access");
   err_data_a: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0) else $error("error read data");
   bad_addr_a: assert property (acc && (paddr[1:0] != 2'h0 || paddr == 12'h008) |-> pslverr)
      else $error("bad address accepted");
   good_addr_a: assert property (acc && paddr == 12'h000 |-> !pslverr) else $error("mapped address refused");
   sys_period_a: assert property (system_clock && pc == 2'h2 |->
      gap == (sel[3] ? 8'h80 : 8'h01 << sel[2:0]) - 8'h01)
      else $error("system tick period");
   peri_idle_a: assert property (!pw |-> peripheral_clock_n == '0) else $error("unselected clock runs");
   cover property (system_clock && pc == 2'h2 && sel != 4'h0);
   cover property (pslverr);
   cover property (peripheral_clock_n[NP-1]);
endmodule

bind cdd_clock_distribution cdd_checker #(.NP(NP)) cdd_checker_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .slow_internal_osc(slow_internal_osc), .slow_root_clock(slow_root_clock),
   .system_clock(system_clock), .peripheral_clock_n(peripheral_clock_n));

// ===== cdd_periph_model.sv
// peripheral model: counts and times the pulses of every peripheral clock
module cdd_periph_model #(
   parameter int NP = 11
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic [NP-1:0] tick,
   output int                 cnt [NP],
   output int                 per [NP]
);
   timeunit 1ns;
   timeprecision 1ps;
   int now;
   int last [NP];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         now <= 0;
         for (int k = 0; k < NP; k++) begin
            cnt[k] <= 0;
            per[k] <= 0;
            last[k] <= 0;
         end
      end else begin
         now <= now + 1;
         for (int k = 0; k < NP; k++) begin
            if (tick[k] === 1'b1) begin
               cnt[k] <= cnt[k] + 1;
               per[k] <= now - last[k];
               last[k] <= now;
            end
         end
      end
   end
endmodule

// ===== clock_divider_distribution_bench.sv
// testbench of the clock distribution block
module clock_divider_distribution_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, slow_internal_osc;
   logic        pready, pslverr, slow_root_clock, system_clock, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [10:0] peripheral_clock_n;
   int          cnt [11];
   int          per [11];
   int          errors, n_compared, n, lo, hi;
   cdd_clock_distribution cdd_clock_distribution_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .slow_internal_osc(slow_internal_osc), .slow_root_clock(slow_root_clock),
      .system_clock(system_clock), .peripheral_clock_n(peripheral_clock_n));
   cdd_periph_model cdd_periph_model_i (
      .pclk(pclk), .presetn(presetn), .tick(peripheral_clock_n), .cnt(cnt), .per(per));
   // ----
   // bus and compare tasks
   // ----
   task chk(input logic [31:0] g, input logic [31:0] x, input string m);
      n_compared++;
      if (g !== x) begin
         errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x, "read data");
   endtask
   task first_pulse;
      int k;
      k = 0;
      do begin
         @(negedge pclk);
         k++;
      end while (k < 20 && peripheral_clock_n[0] !== 1'b1);
      chk(k, 7, "first pulse delay");
   endtask
   // ----
   // scenarios
   // ----
   task t_regs;
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h0000ffff);
      rd(12'h100, 32'h0);
      rd(12'h300, 32'h0);
      wr(12'h008, 32'hffffffff);
      chk(e, 1, "hole write refused");
      rd(12'h00a, 32'h0);
      chk(e, 1, "misaligned refused");
      repeat (2) begin
         @(negedge pclk);
         chk(slow_root_clock, slow_internal_osc, "slow root clock");
      end
      $display("test regs done");
   endtask
   task t_presc;
      for (int s = 0; s < 9; s++) begin
         wr(12'h000, (s == 8) ? 32'hc : s);
         repeat (300) @(posedge pclk);
         n = 0;
         repeat (256) begin
            @(negedge pclk);
            if (system_clock === 1'b1) n++;
         end
         chk(n, 256 >> ((s > 7) ? 7 : s), "system ticks");
      end
      wr(12'h000, 32'h0);
      $display("test prescaler done");
   endtask
   task t_int;
      wr(12'h100, 32'h300);
      wr(12'h104, 32'h500);
      wr(12'h300, 32'h40);
      wr(12'h304, 32'h41);
      wr(12'h328, 32'h41);
      wr(12'h308, 32'h47);
      wr(12'h30c, 32'h01);
      wr(12'h004, 32'h8000ff40);
      first_pulse;
      rd(12'h100, 32'h301);
      wr(12'h004, 32'h80004041);
      rd(12'h004, 32'h00004041);
      repeat (50) @(posedge pclk);
      chk(per[0], 4, "int0 period");
      chk(per[1], 6, "int1 period");
      chk(per[10], 6, "last output");
      chk(cnt[2], 0, "absent divider");
      chk(cnt[3], 0, "kind zero");
      n = 0;
      repeat (24) begin
         @(negedge pclk);
         if (peripheral_clock_n[1:0] === 2'b11) n++;
      end
      chk(n, 2, "coincident ticks");
      wr(12'h004, 32'h40000040);
      repeat (4) @(posedge pclk);
      lo = cnt[0];
      repeat (20) @(posedge pclk);
      chk(cnt[0] - lo, 0, "disabled quiet");
      rd(12'h100, 32'h300);
      wr(12'h004, 32'h8000ff40);
      first_pulse;
      wr(12'h004, 32'hc0000040);
      rd(12'h100, 32'h300);
      wr(12'h004, 32'h8000ffff);
      rd(12'h004, 32'h0000ffff);
      $display("test integer done");
   endtask
   task t_frac;
      wr(12'h200, 32'h380);
      wr(12'h310, 32'h80);
      wr(12'h004, 32'h8000ff80);
      repeat (40) @(posedge pclk);
      rd(12'h200, 32'h381);
      n = 0;
      lo = 99;
      hi = 0;
      repeat (144) begin
         @(negedge pclk);
         if (peripheral_clock_n[4] === 1'b1) begin
            n++;
            lo = (per[4] < lo) ? per[4] : lo;
            hi = (per[4] > hi) ? per[4] : hi;
         end
      end
      chk(n, 32, "fraction average");
      chk(lo, 4, "short period");
      chk(hi, 5, "long period");
      $display("test fraction done");
   endtask
   task summarize;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) slow_internal_osc <= ~slow_internal_osc;
   initial begin
      repeat (30000) @(posedge pclk);
      errors++;
      $display("MISMATCH %0t watchdog expired", $time);
      summarize;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      slow_internal_osc = 1'b0;
      errors = 0;
      n_compared = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_presc;
      t_int;
      t_frac;
      summarize;
   end
endmodule
